/* File: hdl/dcc_channel.sv */
/*
 One comparator channel: synchroniser, edge flags, interrupt request, pin gating.
 Assumes cmp_raw comes straight from the analog comparator, unclocked.
*/
module dcc_channel
    import dcc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic cmp_raw,
    input  wire logic channel_on,
    input  wire logic rise_irq_on,
    input  wire logic fall_irq_on,
    input  wire logic clr_rise,
    input  wire logic clr_fall,
    output logic      raw_pin,
    output logic      sync_q,
    output logic      rise_flag_q,
    output logic      fall_flag_q,
    output logic      irq_req,
    output logic      rise_evt,
    output logic      fall_evt
);
    logic meta_q;
    logic prev_q;

    // Raw path bypasses the clock entirely
    assign raw_pin = cmp_raw & channel_on;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= cmp_raw;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) prev_q <= 1'b0;
        else        prev_q <= sync_q;
    end

    assign rise_evt = sync_q & ~prev_q;
    assign fall_evt = ~sync_q & prev_q;

    // Hardware set wins over software clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else begin
            if (rise_evt)      rise_flag_q <= 1'b1;
            else if (clr_rise) rise_flag_q <= 1'b0;
            if (fall_evt)      fall_flag_q <= 1'b1;
            else if (clr_fall) fall_flag_q <= 1'b0;
        end
    end

    assign irq_req = (rise_flag_q & rise_irq_on) | (fall_flag_q & fall_irq_on);
endmodule : dcc_channel

/* File: hdl/dcc_top.sv */
/*
 Dual comparator control: APB registers, two channels, interrupt and reset request.
 Assumes an APB master on ref_clk and analog comparators driving cmp_*_raw_in.
*/
// Summary of operation
// - Two identical channels; channel A requests reset
// - Raw unclocked result plus synchronised latched result
// - Two-bit positive and negative input selectors
// - Disabled channel: pin low, power off
// - Mode field selects response speed
// - Separate positive and negative hysteresis fields
// - Interrupt on rising, falling or both
// - Falling transition sets falling flag
// - Rising transition sets rising flag
// - Flags sticky until software writes zero
// - Read-only bit shows current result
// - Enable bit one on, zero off
// - Rise/fall interrupt enables at bits 5,4
// - Hysteresis code 00 off, 11 largest
// - Mode 00 fastest, 11 slowest
`include "dcc_map.svh"
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire logic             cmp_a_raw_in,
    input  wire logic             cmp_b_raw_in,
    output logic                  cmp_a_raw_out,
    output logic                  cmp_b_raw_out,
    output logic                  cmp_a_sync_out,
    output logic                  cmp_b_sync_out,
    output dcc_analog_cfg_s       cmp_a_cfg,
    output dcc_analog_cfg_s       cmp_b_cfg,
    output logic                  cmp_a_reset_req,
    output logic                  irq
);
    logic [7:0] a_ctrl_q, a_mode_q, a_mux_q;
    logic [7:0] b_ctrl_q, b_mode_q, b_mux_q;
    logic [3:0] irq_stat_q, irq_mask_q;
    logic       a_sync, b_sync, a_rf, a_ff, b_rf, b_ff;
    logic       a_irq, b_irq, a_rev, a_fev, b_rev, b_fev;
    logic       a_raw_pin, b_raw_pin;
    logic       wr, access, hit;
    logic [31:0] rdata_d;

    function automatic logic [31:0] word(input logic [7:0] v);
        word = {24'h00_0000, v};
    endfunction : word

    // Write-zero-to-clear for edge flags in a control register
    function automatic logic clr_by_zero(input logic we, input logic [31:0] d,
                                         input int bitpos);
        clr_by_zero = we & ~d[bitpos];
    endfunction : clr_by_zero

    function automatic dcc_analog_cfg_s mk_cfg(input logic [7:0] c, input logic [7:0] m,
                                               input logic [7:0] x);
        mk_cfg.pos_hyst_sel       = c[`DCC_CTRL_HYP_LSB +: 2];
        mk_cfg.neg_hyst_sel       = c[`DCC_CTRL_HYN_LSB +: 2];
        mk_cfg.response_speed_sel = m[`DCC_MODE_MD_LSB +: 2];
        mk_cfg.pos_sel            = x[`DCC_MUX_POS_LSB +: 2];
        mk_cfg.neg_sel            = x[`DCC_MUX_NEG_LSB +: 2];
        mk_cfg.power_on           = c[`DCC_CTRL_ON_BIT];
    endfunction : mk_cfg

    assign access = psel & penable;
    assign wr     = access & pwrite;

    logic wr_a_ctrl, wr_b_ctrl;
    assign wr_a_ctrl = wr & (paddr == `DCC_OFF_A_CTRL);
    assign wr_b_ctrl = wr & (paddr == `DCC_OFF_B_CTRL);

    dcc_channel u_ch_a (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .cmp_raw     (cmp_a_raw_in),
        .channel_on  (a_ctrl_q[`DCC_CTRL_ON_BIT]),
        .rise_irq_on (a_mode_q[`DCC_MODE_RIE_BIT]),
        .fall_irq_on (a_mode_q[`DCC_MODE_FIE_BIT]),
        .clr_rise    (clr_by_zero(wr_a_ctrl, pwdata, `DCC_CTRL_RISE_BIT)),
        .clr_fall    (clr_by_zero(wr_a_ctrl, pwdata, `DCC_CTRL_FALL_BIT)),
        .raw_pin     (a_raw_pin),
        .sync_q      (a_sync),
        .rise_flag_q (a_rf),
        .fall_flag_q (a_ff),
        .irq_req     (a_irq),
        .rise_evt    (a_rev),
        .fall_evt    (a_fev)
    );

    dcc_channel u_ch_b (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .cmp_raw     (cmp_b_raw_in),
        .channel_on  (b_ctrl_q[`DCC_CTRL_ON_BIT]),
        .rise_irq_on (b_mode_q[`DCC_MODE_RIE_BIT]),
        .fall_irq_on (b_mode_q[`DCC_MODE_FIE_BIT]),
        .clr_rise    (clr_by_zero(wr_b_ctrl, pwdata, `DCC_CTRL_RISE_BIT)),
        .clr_fall    (clr_by_zero(wr_b_ctrl, pwdata, `DCC_CTRL_FALL_BIT)),
        .raw_pin     (b_raw_pin),
        .sync_q      (b_sync),
        .rise_flag_q (b_rf),
        .fall_flag_q (b_ff),
        .irq_req     (b_irq),
        .rise_evt    (b_rev),
        .fall_evt    (b_fev)
    );

    // Raw result must pass even without clock, so not registered
    assign cmp_a_raw_out = a_raw_pin;
    assign cmp_b_raw_out = b_raw_pin;

    // Control, mode and input-select registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a_ctrl_q <= `DCC_CTRL_RESET;
            b_ctrl_q <= `DCC_CTRL_RESET;
            a_mode_q <= `DCC_MODE_RESET;
            b_mode_q <= `DCC_MODE_RESET;
            a_mux_q  <= `DCC_MUX_RESET;
            b_mux_q  <= `DCC_MUX_RESET;
        end else if (wr) begin
            case (paddr)
                `DCC_OFF_A_CTRL: a_ctrl_q <= pwdata[7:0] & 8'h8F;
                `DCC_OFF_B_CTRL: b_ctrl_q <= pwdata[7:0] & 8'h8F;
                `DCC_OFF_A_MODE: a_mode_q <= pwdata[7:0] & 8'h33;
                `DCC_OFF_B_MODE: b_mode_q <= pwdata[7:0] & 8'h33;
                `DCC_OFF_A_MUX:  a_mux_q  <= pwdata[7:0] & 8'h33;
                `DCC_OFF_B_MUX:  b_mux_q  <= pwdata[7:0] & 8'h33;
                default: ;
            endcase
        end
    end

    // Sticky edge status, write one to clear, set wins
    logic [3:0] evt;
    assign evt = {b_fev, b_rev, a_fev, a_rev};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_q <= 4'h0;
        end else if (wr && paddr == `DCC_OFF_IRQ_STAT) begin
            irq_stat_q <= evt | (irq_stat_q & ~pwdata[3:0]);
        end else begin
            irq_stat_q <= evt | irq_stat_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)                                irq_mask_q <= 4'h0;
        else if (wr && paddr == `DCC_OFF_IRQ_MASK) irq_mask_q <= pwdata[3:0];
    end

    // Interrupt: per-edge enables plus the masked status
    always_ff @(posedge ref_clk) begin
        if (!rst_n) irq <= 1'b0;
        else        irq <= a_irq | b_irq | (|(irq_stat_q & irq_mask_q));
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmp_a_sync_out  <= 1'b0;
            cmp_b_sync_out  <= 1'b0;
            cmp_a_reset_req <= 1'b0;
            cmp_a_cfg       <= '0;
            cmp_b_cfg       <= '0;
        end else begin
            cmp_a_sync_out  <= a_sync & a_ctrl_q[`DCC_CTRL_ON_BIT];
            cmp_b_sync_out  <= b_sync & b_ctrl_q[`DCC_CTRL_ON_BIT];
            cmp_a_reset_req <= a_ctrl_q[`DCC_CTRL_ON_BIT] & ~a_sync;
            cmp_a_cfg       <= mk_cfg(a_ctrl_q, a_mode_q, a_mux_q);
            cmp_b_cfg       <= mk_cfg(b_ctrl_q, b_mode_q, b_mux_q);
        end
    end

    // Read decode; output bit shows the current synchronised result
    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            `DCC_OFF_A_CTRL: rdata_d = word({a_ctrl_q[7], a_sync, a_rf, a_ff,
                                             a_ctrl_q[3:0]});
            `DCC_OFF_B_CTRL: rdata_d = word({b_ctrl_q[7], b_sync, b_rf, b_ff,
                                             b_ctrl_q[3:0]});
            `DCC_OFF_A_MODE: rdata_d = word(a_mode_q);
            `DCC_OFF_B_MODE: rdata_d = word(b_mode_q);
            `DCC_OFF_A_MUX:  rdata_d = word(a_mux_q);
            `DCC_OFF_B_MUX:  rdata_d = word(b_mux_q);
            `DCC_OFF_IRQ_STAT: rdata_d = {28'h000_0000, irq_stat_q};
            `DCC_OFF_IRQ_MASK: rdata_d = {28'h000_0000, irq_mask_q};
            default:         hit = 1'b0;
        endcase
    end

    // No wait state: ready in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
            pslverr <= psel & ~penable & ~hit;
        end
    end
endmodule : dcc_top

/* File: inc/dcc_map.svh */
/*
 Register offsets, field positions, reset values for the dual comparator control.
 Assumes inclusion by the package and the main design file only.
*/
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

`define DCC_OFF_A_CTRL      12'h000
`define DCC_OFF_A_MODE      12'h004
`define DCC_OFF_A_MUX       12'h008
`define DCC_OFF_B_CTRL      12'h00C
`define DCC_OFF_B_MODE      12'h010
`define DCC_OFF_B_MUX       12'h014
`define DCC_OFF_IRQ_STAT    12'h018
`define DCC_OFF_IRQ_MASK    12'h01C

`define DCC_CTRL_ON_BIT     7
`define DCC_CTRL_OUT_BIT    6
`define DCC_CTRL_RISE_BIT   5
`define DCC_CTRL_FALL_BIT   4
`define DCC_CTRL_HYP_LSB    2
`define DCC_CTRL_HYN_LSB    0
`define DCC_MODE_RIE_BIT    5
`define DCC_MODE_FIE_BIT    4
`define DCC_MODE_MD_LSB     0
`define DCC_MUX_NEG_LSB     4
`define DCC_MUX_POS_LSB     0

`define DCC_CTRL_RESET      8'h00
`define DCC_MODE_RESET      8'h02
`define DCC_MUX_RESET       8'h00
`define DCC_SYNC_STAGES     2

`endif

/* File: inc/dcc_pkg.sv */
/*
 Types for the dual comparator control block.
 Assumes dcc_map.svh lies on the include path.
*/
package dcc_pkg;
    `include "dcc_map.svh"

    typedef struct packed {
        logic [1:0] pos_hyst_sel;
        logic [1:0] neg_hyst_sel;
        logic [1:0] response_speed_sel;
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        logic       power_on;
    } dcc_analog_cfg_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } dcc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } dcc_apb_rsp_s;

    typedef enum logic [1:0] {
        DCC_SPEED_FAST,
        DCC_SPEED_MID1,
        DCC_SPEED_MID2,
        DCC_SPEED_SLOW
    } dcc_speed_e;
endpackage : dcc_pkg

/* File: sim/dcc_analog_model.sv */
/* Analog side: comparator results that follow bench-set levels.
   Assumes the bench sets levels between clock edges. */
module dcc_analog_model (
    input  wire logic lvl_a,
    input  wire logic lvl_b,
    output logic      raw_a,
    output logic      raw_b
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(lvl_a) raw_a <= #1 lvl_a;
    always @(lvl_b) raw_b <= #1 lvl_b;
endmodule : dcc_analog_model

/* File: sim/dcc_top_assertions.sv */
/* Port checker for dcc_top, bound at the file foot.
   Assumes one clock and a synchronous active-low reset. */
module dcc_top_assertions
    import dcc_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rst_n,
    input wire logic [11:0]     paddr,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            cmp_a_raw_in,
    input wire logic            cmp_a_raw_out,
    input wire logic            cmp_b_raw_out,
    input wire logic            cmp_a_sync_out,
    input wire logic            cmp_b_sync_out,
    input wire dcc_analog_cfg_s cmp_a_cfg,
    input wire dcc_analog_cfg_s cmp_b_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_a_raw_gate: assert property (!cmp_a_cfg.power_on |-> !$past(cmp_a_raw_out))
        else $error("A pin high while off");
    chk_b_raw_gate: assert property (!cmp_b_cfg.power_on |-> !$past(cmp_b_raw_out))
        else $error("B pin high while off");
    chk_a_raw_follow: assert property (cmp_a_cfg.power_on |->
        $past(cmp_a_raw_out) == $past(cmp_a_raw_in))
        else $error("A raw pin wrong");
    chk_a_sync_path: assert property (cmp_a_cfg.power_on [*4] |->
        cmp_a_sync_out == $past(cmp_a_raw_in, 3))
        else $error("A sync output late or wrong");
    chk_b_sync_off: assert property ((!cmp_b_cfg.power_on) [*2] |-> !cmp_b_sync_out)
        else $error("B sync output high while off");
    chk_ready_access: assert property (psel && !penable |=> pready)
        else $error("No ready in access cycle");
    chk_ready_only: assert property (pready |-> psel && penable)
        else $error("Ready outside access");
    chk_err_map: assert property (pready |-> pslverr == (paddr > 12'h01C))
        else $error("Error response wrong");
endmodule : dcc_top_assertions

bind dcc_top dcc_top_assertions chk_u (.*);

/* File: sim/dcc_top_bench.sv */
/* Bench for dcc_top: APB master tasks, analog model, one task per scenario.
   Assumes dcc_pkg is compiled first. */
module dcc_top_bench
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic            ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic            cmp_a_raw_in, cmp_b_raw_in, cmp_a_raw_out, cmp_b_raw_out, err;
    logic            cmp_a_sync_out, cmp_b_sync_out, cmp_a_reset_req, lvl_a, lvl_b;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    dcc_analog_cfg_s cmp_a_cfg, cmp_b_cfg;
    int              err_count, checks;

    dcc_top dut (.*);
    dcc_analog_model pins (.lvl_a(lvl_a), .lvl_b(lvl_b), .raw_a(cmp_a_raw_in),
                           .raw_b(cmp_b_raw_in));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        chk(n < 50, 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask : wr

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rc

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wt

    task automatic t_reset;
        rc(12'h004, 8'h02);
        rc(12'h010, 8'h02);
        rc(12'h00C, 8'h00);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
    endtask : t_reset

    task automatic t_fields;
        logic [11:0] b;
        for (int i = 0; i < 4; i++) begin
            for (int ch = 0; ch < 2; ch++) begin
                b = ch ? 12'h00C : 12'h000;
                wr(b, {4'h8, i[1:0], ~i[1:0]});
                wr(b + 12'h004, {6'h33, i[1:0]});
                rc(b + 12'h004, i[1:0]);
                wr(b + 12'h008, {2'h0, ~i[1:0], 2'h0, i[1:0]});
                wt(2);
                chk(ch ? cmp_b_cfg : cmp_a_cfg,
                    {i[1:0], ~i[1:0], i[1:0], i[1:0], ~i[1:0], 1'b1});
            end
        end
        lvl_a <= 1'b1;
        lvl_b <= 1'b1;
        wt(2);
        chk({cmp_a_raw_out, cmp_b_raw_out}, 2'b11);
        wr(12'h000, 8'h00);
        wr(12'h00C, 8'h00);
        wt(2);
        chk({cmp_a_raw_out, cmp_b_raw_out, cmp_a_cfg.power_on, cmp_b_sync_out}, 4'h0);
        lvl_a <= 1'b0;
    endtask : t_fields

    task automatic t_edges;
        wr(12'h000, 8'h80);
        wt(6);
        wr(12'h000, 8'h80);
        rc(12'h000, 8'h80);
        lvl_a <= 1'b1;
        wt(6);
        chk({cmp_a_sync_out, cmp_a_reset_req}, 2'b10);
        rc(12'h000, 8'hE0);
        lvl_a <= 1'b0;
        wt(6);
        chk({cmp_a_sync_out, cmp_a_reset_req}, 2'b01);
        rc(12'h000, 8'hB0);
        wr(12'h000, 8'hB0);
        rc(12'h000, 8'hB0);
        wr(12'h000, 8'h80);
        rc(12'h000, 8'h80);
    endtask : t_edges

    task automatic t_irq;
        wr(12'h018, 8'h0F);
        wr(12'h004, 8'h22);
        wt(2);
        chk(irq, 1'b0);
        lvl_a <= 1'b1;
        wt(6);
        chk(irq, 1'b1);
        wr(12'h000, 8'h80);
        wr(12'h018, 8'h0F);
        wt(2);
        chk(irq, 1'b0);
        wr(12'h004, 8'h02);
        wr(12'h01C, 8'h02);
        lvl_a <= 1'b0;
        wt(6);
        chk(irq, 1'b1);
        rc(12'h018, 8'h02);
        wr(12'h018, 8'h02);
        wt(2);
        chk(irq, 1'b0);
        wr(12'h01C, 8'h00);
        lvl_a <= 1'b1;
        wt(6);
        chk(irq, 1'b0);
    endtask : t_irq

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        lvl_a   = 1'b0;
        lvl_b   = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_fields;
        t_edges;
        t_irq;
        tally_and_finish;
    end

    initial begin
        #100us;
        err_count++;
        tally_and_finish;
    end
endmodule : dcc_top_bench
